// *** timer16_pkg.sv ***
// What this block does
// RQ1: 16-bit up-counter read as high/low bytes via main and alias views.
// RQ2: counter clock is cpu clock divided by 2, 4 or 8, or external input.
// RQ3: writing main or alias low byte forces the counter to FFFCh.
// RQ4: reset loads FFFCh; FFFCh is the only reload value.
// RQ5: high byte read first latches low byte until low byte is read.
// RQ6: after a full sequence a lone low byte read returns the live byte.
// RQ7: rollover from FFFFh to 0000h sets the rollover flag.
// RQ8: rollover request only while enabled and global mask clear, else pending.
// RQ9: rollover flag clears by flag register read then main low byte access.
// RQ10: alias low byte accesses never clear the rollover flag.
// RQ11: counting continues in wait, stops in halt, resumes from held count.
// RQ12: both clock select bits set picks the external count input.
// RQ13: an edge select bit picks the counting edge of the external input.
// RQ14: counter updates are synchronised to the cpu clock.
// RQ15: external clock needs four cpu clocks between active edges.
// RQ16: active capture pin edge latches counter and sets that capture flag.
// RQ17: each capture channel has its own software edge select bit.
// RQ18: capture request when a flag set, enabled and global mask clear.
// RQ19: capture flag clears by flag register read then its low byte access.
// RQ20: reading capture high byte blocks transfers until its low byte read.
// RQ21: capture register holds the most recent count captured while its transfers are not blocked.
// RQ22: in halt a capture edge only arms; flag and data appear on wake.
package timer16_pkg;

    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [7:0] counter_high_byte_addr       = 8'h00;
    localparam logic [7:0] counter_low_byte_addr        = 8'h04;
    localparam logic [7:0] alias_count_high_byte_addr   = 8'h08;
    localparam logic [7:0] alias_count_low_byte_addr    = 8'h0c;
    localparam logic [7:0] capture1_high_byte_addr      = 8'h10;
    localparam logic [7:0] capture1_low_byte_addr       = 8'h14;
    localparam logic [7:0] capture2_high_byte_addr      = 8'h18;
    localparam logic [7:0] capture2_low_byte_addr       = 8'h1c;
    localparam logic [7:0] timer_flag_register_addr     = 8'h20;
    localparam logic [7:0] timer_control_one_addr       = 8'h24;
    localparam logic [7:0] timer_control_two_addr       = 8'h28;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int rollover_flag_bit       = 0;
    localparam int capture_flag_lsb        = 1;
    localparam int rollover_irq_enable_bit = 0;
    localparam int capture_irq_enable_bit  = 1;
    localparam int capture_edge_one_bit    = 2;
    localparam int clock_select_lsb        = 0;
    localparam int ext_edge_select_bit     = 2;
    localparam int capture_edge_two_bit    = 3;

    // ************************************************************
    // values after reset and counts
    // ************************************************************
    localparam logic [15:0] counter_reload_value = 16'hfffc;
    localparam logic [7:0]  control_reset_value  = 8'h00;
    localparam logic [1:0]  clock_select_div2    = 2'h0;
    localparam logic [1:0]  clock_select_div4    = 2'h1;
    localparam logic [1:0]  clock_select_div8    = 2'h2;
    localparam logic [1:0]  clock_select_ext     = 2'h3;
    localparam int          ext_min_edge_gap     = 4;

endpackage : timer16_pkg

// *** timer16_counter_capture.sv ***
module timer16_counter_capture #(
    parameter int channels = 2
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic                ext_count_input,
    input  wire logic [channels-1:0] capture_pin,
    input  wire logic                cpu_irq_mask,
    input  wire logic                halt_mode,
    output logic                     rollover_irq,
    output logic                     capture_irq
);

    // ************************************************************
    // bus slave
    // ************************************************************
    logic        access;
    logic [7:0]  addr_byte;
    logic        rd;
    logic        wr;
    logic        wr_pending;
    logic [7:0]  wr_addr;

    assign access    = hsel & hready & htrans[1];
    assign addr_byte = haddr[7:0];
    assign rd        = access & ~hwrite;
    assign wr        = access & hwrite;
    // zero wait states: every read side effect happens at the address edge
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_addr    <= 8'h00;
        end else begin
            wr_pending <= wr;
            wr_addr    <= addr_byte;
        end
    end

    logic rd_chigh;
    logic rd_clow;
    logic rd_ahigh;
    logic rd_alow;
    logic rd_flags;
    logic acc_clow;
    logic acc_alow;

    assign rd_chigh = rd & (addr_byte == timer16_pkg::counter_high_byte_addr);
    assign rd_clow  = rd & (addr_byte == timer16_pkg::counter_low_byte_addr);
    assign rd_ahigh = rd
        & (addr_byte == timer16_pkg::alias_count_high_byte_addr);
    assign rd_alow  = rd
        & (addr_byte == timer16_pkg::alias_count_low_byte_addr);
    assign rd_flags = rd
        & (addr_byte == timer16_pkg::timer_flag_register_addr);
    assign acc_clow = access
        & (addr_byte == timer16_pkg::counter_low_byte_addr);
    assign acc_alow = access
        & (addr_byte == timer16_pkg::alias_count_low_byte_addr);

    // ************************************************************
    // control registers
    // ************************************************************
    logic [7:0] timer_control_one;
    logic [7:0] timer_control_two;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control_one <= timer16_pkg::control_reset_value;
            timer_control_two <= timer16_pkg::control_reset_value;
        end else if (wr_pending) begin
            if (wr_addr == timer16_pkg::timer_control_one_addr) begin
                timer_control_one <= hwdata[7:0];
            end
            if (wr_addr == timer16_pkg::timer_control_two_addr) begin
                timer_control_two <= hwdata[7:0];
            end
        end
    end

    logic       rollover_irq_enable;
    logic       capture_irq_enable;
    logic [1:0] clock_select_bits;
    logic       ext_edge_select;
    logic [channels-1:0] capture_edge_select;

    assign rollover_irq_enable =
        timer_control_one[timer16_pkg::rollover_irq_enable_bit];
    assign capture_irq_enable =
        timer_control_one[timer16_pkg::capture_irq_enable_bit];
    assign clock_select_bits =
        timer_control_two[timer16_pkg::clock_select_lsb +: 2];
    assign ext_edge_select =
        timer_control_two[timer16_pkg::ext_edge_select_bit];

    // [RQ17]
    always_comb begin
        capture_edge_select = '0;
        capture_edge_select[0] =
            timer_control_one[timer16_pkg::capture_edge_one_bit];
        if (channels > 1) begin
            capture_edge_select[channels-1] =
                timer_control_two[timer16_pkg::capture_edge_two_bit];
        end
    end

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // a change counts once stages two and three agree
    localparam int pins = channels + 1;
    logic [pins-1:0] pin_raw;
    logic [pins-1:0] rise;
    logic [pins-1:0] fall;

    assign pin_raw = {capture_pin, ext_count_input};

    genvar g;
    generate
        for (g = 0; g < pins; g++) begin : g_sync
            logic s1;
            logic s2;
            logic s3;
            logic level;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1    <= 1'b0;
                    s2    <= 1'b0;
                    s3    <= 1'b0;
                    level <= 1'b0;
                end else begin
                    s1 <= pin_raw[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        level <= s3;
                    end
                end
            end
            assign rise[g] = (s2 == s3) & s3 & ~level;
            assign fall[g] = (s2 == s3) & ~s3 & level;
        end
    endgenerate

    // ************************************************************
    // prescaler and count enable
    // ************************************************************
    logic [2:0] prescale;
    logic       div_tick;
    logic       ext_tick;
    logic       count_tick;

    // free-running divider; halt freezes it along with the counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale <= 3'h0;
        end else if (!halt_mode) begin
            prescale <= prescale + 3'h1;
        end
    end

    always_comb begin
        case (clock_select_bits)
            timer16_pkg::clock_select_div2: div_tick = prescale[0];
            timer16_pkg::clock_select_div4: div_tick = &prescale[1:0];
            timer16_pkg::clock_select_div8: div_tick = &prescale;
            default:                        div_tick = 1'b0;
        endcase
    end

    // edges closer than four clocks are the source's fault and may merge
    assign ext_tick = ext_edge_select ? rise[0] : fall[0]; // [RQ13] [RQ15]
    // counting is a clock enable on hclk, never a derived clock [RQ14]
    assign count_tick = ~halt_mode                                 // [RQ11]
        & ((clock_select_bits == timer16_pkg::clock_select_ext)    // [RQ12]
           ? ext_tick : div_tick);                                  // [RQ2]

    // ************************************************************
    // free running counter
    // ************************************************************
    logic [15:0] count;
    logic        count_reload;

    assign count_reload = wr & (acc_clow | acc_alow);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= timer16_pkg::counter_reload_value;            // [RQ4]
        end else if (count_reload) begin
            count <= timer16_pkg::counter_reload_value;            // [RQ3]
        end else if (count_tick) begin
            count <= count + 16'h0001;                             // [RQ1]
        end
    end

    // ************************************************************
    // 16-bit read buffering
    // ************************************************************
    logic       low_held;
    logic [7:0] low_buffer;

    // one buffer serves both views, they show the same count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_held   <= 1'b0;
            low_buffer <= 8'h00;
        end else if (rd_clow | rd_alow) begin
            low_held <= 1'b0;                                      // [RQ6]
        end else if ((rd_chigh | rd_ahigh) & ~low_held) begin
            low_held   <= 1'b1;                                    // [RQ5]
            low_buffer <= count[7:0];
        end
    end

    // ************************************************************
    // rollover flag
    // ************************************************************
    logic rollover_flag;
    logic rollover_armed;
    logic rollover_event;

    assign rollover_event = count_tick & ~count_reload
        & (count == 16'hffff);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rollover_flag  <= 1'b0;
            rollover_armed <= 1'b0;
        end else begin
            if (rd_flags) begin
                rollover_armed <= rollover_flag;
            end else if (acc_clow) begin
                rollover_armed <= 1'b0;
            end
            // alias low byte is never decoded here [RQ10]
            if (rollover_event) begin
                rollover_flag <= 1'b1;                             // [RQ7]
            end else if (acc_clow & rollover_armed) begin
                rollover_flag <= 1'b0;                             // [RQ9]
            end
        end
    end

    assign rollover_irq = rollover_flag & rollover_irq_enable
        & ~cpu_irq_mask;                                           // [RQ8]

    // ************************************************************
    // capture channels
    // ************************************************************
    logic [15:0]         capture_value [channels];
    logic [channels-1:0] capture_flag;
    logic [channels-1:0] capture_armed;
    logic [channels-1:0] capture_blocked;
    logic [channels-1:0] cap_rd_high;
    logic [channels-1:0] cap_rd_low;
    logic [channels-1:0] cap_acc_low;

    generate
        for (g = 0; g < channels; g++) begin : g_cap
            logic [7:0]  high_addr;
            logic [7:0]  low_addr;
            logic        edge_hit;
            logic        halt_seen;
            logic [15:0] halt_value;
            logic        take;
            logic [15:0] take_value;

            assign high_addr = timer16_pkg::capture1_high_byte_addr
                + 8'(8 * g);
            assign low_addr  = timer16_pkg::capture1_low_byte_addr
                + 8'(8 * g);
            assign cap_rd_high[g] = rd & (addr_byte == high_addr);
            assign cap_rd_low[g]  = rd & (addr_byte == low_addr);
            assign cap_acc_low[g] = access & (addr_byte == low_addr);
            assign edge_hit = capture_edge_select[g]
                ? rise[g+1] : fall[g+1];                           // [RQ17]

            // a wake-up replays the first edge seen during halt
            assign take = (~halt_mode & edge_hit)
                | (~halt_mode & halt_seen);                        // [RQ16]
            assign take_value = halt_seen ? halt_value : count;

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    halt_seen  <= 1'b0;
                    halt_value <= 16'h0000;
                end else if (halt_mode & edge_hit & ~halt_seen) begin
                    halt_seen  <= 1'b1;                            // [RQ22]
                    halt_value <= count;
                end else if (~halt_mode) begin
                    halt_seen <= 1'b0;
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    capture_blocked[g] <= 1'b0;
                end else if (cap_rd_low[g]) begin
                    capture_blocked[g] <= 1'b0;
                end else if (cap_rd_high[g]) begin
                    capture_blocked[g] <= 1'b1;                    // [RQ20]
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    capture_value[g] <= 16'h0000;
                end else if (take & ~capture_blocked[g]) begin
                    capture_value[g] <= take_value;                // [RQ21]
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    capture_flag[g]  <= 1'b0;
                    capture_armed[g] <= 1'b0;
                end else begin
                    if (rd_flags) begin
                        capture_armed[g] <= capture_flag[g];
                    end else if (cap_acc_low[g]) begin
                        capture_armed[g] <= 1'b0;
                    end
                    if (take) begin
                        capture_flag[g] <= 1'b1;                   // [RQ16]
                    end else if (cap_acc_low[g] & capture_armed[g]) begin
                        capture_flag[g] <= 1'b0;                   // [RQ19]
                    end
                end
            end
        end
    endgenerate

    assign capture_irq = (|capture_flag) & capture_irq_enable
        & ~cpu_irq_mask;                                           // [RQ18]

    // ************************************************************
    // read data
    // ************************************************************
    logic [7:0] next_read_byte;

    always_comb begin
        next_read_byte = 8'h00;
        case (addr_byte)
            timer16_pkg::counter_high_byte_addr,
            timer16_pkg::alias_count_high_byte_addr: begin
                next_read_byte = count[15:8];                      // [RQ1]
            end
            timer16_pkg::counter_low_byte_addr,
            timer16_pkg::alias_count_low_byte_addr: begin
                next_read_byte = low_held ? low_buffer
                                          : count[7:0];            // [RQ5]
            end
            timer16_pkg::timer_flag_register_addr: begin
                next_read_byte[timer16_pkg::rollover_flag_bit] =
                    rollover_flag;
                next_read_byte[timer16_pkg::capture_flag_lsb +: channels] =
                    capture_flag;
            end
            timer16_pkg::timer_control_one_addr: begin
                next_read_byte = timer_control_one;
            end
            timer16_pkg::timer_control_two_addr: begin
                next_read_byte = timer_control_two;
            end
            default: begin
                for (int i = 0; i < channels; i++) begin
                    if (cap_rd_high[i]) begin
                        next_read_byte = capture_value[i][15:8];
                    end
                    if (cap_rd_low[i]) begin
                        next_read_byte = capture_value[i][7:0];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd) begin
            hrdata <= {24'h000000, next_read_byte};
        end
    end

endmodule : timer16_counter_capture

// *** timer16_counter_capture_properties.sv ***
module timer16_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        cpu_irq_mask,
    input wire logic        rollover_irq,
    input wire logic        capture_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // bus and interrupt properties
    // ****************************************
    logic rd_tk;
    logic wr_tk;
    assign rd_tk = hsel && hready && htrans[1] && !hwrite;
    assign wr_tk = hsel && hready && htrans[1] && hwrite;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ready_always_a: assert property (hreadyout)
        else $error("hreadyout dropped");
    okay_resp_a: assert property (!hresp)
        else $error("response not okay");
    roll_masked_a: assert property (cpu_irq_mask |-> !rollover_irq)
        else $error("rollover request while masked");
    cap_masked_a: assert property (cpu_irq_mask |-> !capture_irq)
        else $error("capture request while masked");
    rdata_hold_a: assert property (!rd_tk |=> $stable(hrdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property
        (rd_tk && haddr[7:0] == 8'h40 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    flag_width_a: assert property
        (rd_tk && haddr[7:0] == 8'h20 |=> hrdata[31:3] == 29'h0)
        else $error("flag register spare bits set");
    reload_high_a: assert property (wr_tk && haddr[7:0] == 8'h04
        ##3 rd_tk && haddr[7:0] == 8'h00 |=> hrdata[7:0] == 8'hff)
        else $error("high byte wrong after reload");
    cover property ($rose(rollover_irq));
    cover property ($rose(capture_irq));
    cover property (wr_tk ##3 rd_tk);
endmodule : timer16_checker

// *** timer16_pins.sv ***
module timer16_pins (
    input wire logic  hclk,
    output logic       ext_count_input,
    output logic [1:0] capture_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ext_count_input = 1'b0;
        capture_pin = 2'h0;
    end
    // four cpu clocks on each level keeps the source slow enough
    task automatic ext_pulse(input int n);
        repeat (n) begin
            @(posedge hclk);
            ext_count_input <= 1'b1;
            repeat (4) @(posedge hclk);
            ext_count_input <= 1'b0;
            repeat (4) @(posedge hclk);
        end
    endtask : ext_pulse
    // settle time covers the three-flop synchroniser
    task automatic cap_set(input int ch, input logic v);
        @(posedge hclk);
        capture_pin[ch] <= v;
        repeat (6) @(posedge hclk);
    endtask : cap_set
endmodule : timer16_pins

// *** timer16_counter_capture_tb.sv ***
module timer16_counter_capture_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] hsize = 3'h0;
    logic hreadyout, hresp, rollover_irq, capture_irq;
    logic [31:0] hrdata;
    logic ext_count_input;
    logic [1:0] capture_pin;
    logic cpu_irq_mask = 1'b1;
    logic halt_mode = 1'b0;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    always #4 hclk = ~hclk;
    timer16_counter_capture u_timer16_counter_capture (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .ext_count_input, .capture_pin, .cpu_irq_mask,
        .halt_mode, .rollover_irq, .capture_irq);
    timer16_pins u_timer16_pins (.hclk, .ext_count_input, .capture_pin);
    // ****************************************
    // bus access and compare tasks
    // ****************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic check8(input logic [7:0] got, input logic [7:0] e);
        checks++;
        if (got !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, e);
        end
    endtask : check8
    // prescaler phase is free, so one count either way is accepted
    task automatic check_near(input logic [7:0] got, input logic [7:0] e);
        logic [7:0] dif;
        dif = got - e;
        checks++;
        if (!(dif inside {8'h00, 8'h01, 8'hff})) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h near %h", $time, got, e);
        end
    endtask : check_near
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] wd, output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] d;
        bus(1'b1, a, v, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        bus(1'b0, a, 8'h00, d);
        check8(d[7:0], e);
    endtask : rd
    task automatic rdn(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        bus(1'b0, a, 8'h00, d);
        check_near(d[7:0], e);
    endtask : rdn
    task automatic irq(input logic [1:0] e);
        #1;
        check8({6'h0, capture_irq, rollover_irq}, {6'h0, e});
    endtask : irq
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h00, 8'hff);
        rd(8'h24, 8'h00);
        rd(8'h28, 8'h00);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        wr(8'h28, 8'h07);
        wr(8'h24, 8'h07);
        wr(8'h04, 8'h00);
        rd(8'h00, 8'hff);
        u_timer16_pins.ext_pulse(1);
        rd(8'h00, 8'hff);
        rd(8'h04, 8'hfc);
        rd(8'h04, 8'hfd);
        rd(8'h0c, 8'hfd);
        u_timer16_pins.ext_pulse(3);
        irq(2'b00);
        cpu_irq_mask <= 1'b0;
        @(posedge hclk);
        irq(2'b01);
        rd(8'h20, 8'h01);
        rd(8'h0c, 8'h00);
        rd(8'h20, 8'h01);
        rd(8'h04, 8'h00);
        rd(8'h20, 8'h00);
        u_timer16_pins.cap_set(0, 1'b1);
        rd(8'h20, 8'h02);
        irq(2'b10);
        rd(8'h10, 8'h00);
        rd(8'h14, 8'h00);
        rd(8'h20, 8'h00);
        u_timer16_pins.ext_pulse(1);
        u_timer16_pins.cap_set(1, 1'b1);
        rd(8'h20, 8'h00);
        u_timer16_pins.ext_pulse(1);
        u_timer16_pins.cap_set(1, 1'b0);
        rd(8'h20, 8'h04);
        rd(8'h18, 8'h00);
        u_timer16_pins.ext_pulse(1);
        u_timer16_pins.cap_set(1, 1'b1);
        u_timer16_pins.cap_set(1, 1'b0);
        rd(8'h1c, 8'h02);
        u_timer16_pins.cap_set(1, 1'b1);
        u_timer16_pins.ext_pulse(1);
        u_timer16_pins.cap_set(1, 1'b0);
        rd(8'h20, 8'h04);
        rd(8'h18, 8'h00);
        rd(8'h1c, 8'h04);
        rd(8'h20, 8'h00);
        halt_mode <= 1'b1;
        u_timer16_pins.ext_pulse(1);
        u_timer16_pins.cap_set(0, 1'b0);
        u_timer16_pins.cap_set(0, 1'b1);
        irq(2'b00);
        halt_mode <= 1'b0;
        repeat (4) @(posedge hclk);
        irq(2'b10);
        rd(8'h20, 8'h02);
        rd(8'h10, 8'h00);
        rd(8'h14, 8'h04);
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h04);
        wr(8'h28, 8'h03);
        wr(8'h04, 8'h00);
        u_timer16_pins.ext_pulse(1);
        rd(8'h04, 8'hfd);
        // divide by 2, 4, 8 over 64 cycles; alias reload on the middle one
        for (int k = 0; k < 3; k++) begin
            wr(8'h28, 8'(k));
            wr(k == 1 ? 8'h0c : 8'h04, 8'h00);
            repeat (61) @(posedge hclk);
            rdn(8'h04, 8'(8'hfc + (64 >> (k + 1))));
        end
        conclude();
    end
endmodule : timer16_counter_capture_tb
bind timer16_counter_capture timer16_checker u_timer16_checker (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .cpu_irq_mask, .rollover_irq,
    .capture_irq);
